// [src/scp_pkg.sv]
// constants and types for the sense clip mode and pass count block
package scp_pkg;
  localparam int unsigned PIN_W        = 8;
  localparam int unsigned GRP_W        = 4;
  localparam int unsigned CNT_W        = 8;
  localparam logic [7:0]  PASS_RESET   = 8'h01;
  localparam logic [7:0]  PASS_MIN     = 8'h01;
  localparam int unsigned EVT_BIT      = 0;
  localparam int unsigned HI_LSB       = 4;
  localparam int unsigned LO_LSB       = 0;
  localparam logic [7:0]  ALL_OUT      = 8'hff;
  localparam logic [7:0]  NONE_OUT     = 8'h00;

  // probe pin uses
  typedef enum logic [1:0] {
    SCP_ALL_INPUT,
    SCP_EVENT_OUT,
    SCP_CMP_OUT
  } scp_mode_t;
endpackage

// [src/scp_pass_counter.sv]
// pass counter that qualifies combined event detections
module scp_pass_counter (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       pass_load,
  input  wire logic [7:0] pass_value,
  input  wire logic       detect,
  output logic      [7:0] pass_count,
  output logic            event_fire
);
  logic [7:0] remaining;
  logic       load_ok;

  // zero is ignored silently, so it must not hold back a fire either
  assign load_ok = pass_load && pass_value >= scp_pkg::PASS_MIN;

  // programmed count, zero refused, keeps old value
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pass_count <= scp_pkg::PASS_RESET;
    end else if (load_ok) begin
      pass_count <= pass_value;
    end
  end

  // remaining detections; reload on load or after firing
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      remaining <= scp_pkg::PASS_RESET;
    end else if (load_ok) begin
      remaining <= pass_value;
    end else if (detect) begin
      if (remaining == scp_pkg::PASS_MIN) begin
        remaining <= pass_count;
      end else begin
        remaining <= remaining - scp_pkg::PASS_MIN;
      end
    end
  end

  // registered one-cycle event pulse
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_fire <= 1'b0;
    end else begin
      event_fire <= detect && !load_ok && remaining == scp_pkg::PASS_MIN;
    end
  end

  AST_FIRE_AFTER_COUNT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    event_fire |-> $past(detect) && $past(remaining) == scp_pkg::PASS_MIN)
    else $error("event fired before pass count reached");
  AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    event_fire |-> remaining == pass_count)
    else $error("counter not reloaded after firing");
  AST_COUNT_RANGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pass_count != 8'h00)
    else $error("pass count left its range");
endmodule

// [src/scp_sense_clip.sv]
// probe pin mode control, event output and pass count top
module scp_sense_clip (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       mode_load,
  input  wire logic [1:0] mode_value,
  input  wire logic       sel_cmp_three,
  input  wire logic       sel_cmp_four,
  input  wire logic       cmp_three_busy,
  input  wire logic       cmp_four_busy,
  input  wire logic [7:0] cmp_three_addr,
  input  wire logic [7:0] cmp_four_addr,
  input  wire logic       cmp_three_hit,
  input  wire logic       cmp_four_hit,
  input  wire logic [7:0] mem_data,
  input  wire logic       event_detect,
  input  wire logic       pass_load,
  input  wire logic [7:0] pass_value,
  input  wire logic [7:0] probe_in,
  output logic      [7:0] probe_out,
  output logic      [7:0] probe_oe,
  output logic      [7:0] trace_data,
  output logic      [7:0] event_term,
  output logic      [1:0] mode_readback,
  output logic            cmp_three_owned,
  output logic            cmp_four_owned,
  output logic            mode_refused,
  output logic      [7:0] pass_count,
  output logic            event_out
);
  scp_pkg::scp_mode_t mode;
  logic [7:0]         in_mask;
  logic [7:0]         out_data;
  logic               accept_three;
  logic               accept_four;
  logic               cmp_ok;
  logic               event_fire;
  logic               event_hold;

  // a busy comparator cannot be taken; comparator mode needs one selected and no selected one busy
  assign accept_three = sel_cmp_three && !cmp_three_busy;
  assign accept_four  = sel_cmp_four && !cmp_four_busy;
  assign cmp_ok = !(sel_cmp_three && cmp_three_busy) && !(sel_cmp_four && cmp_four_busy)
                  && (sel_cmp_three || sel_cmp_four);

  // mode register; refused requests leave the old mode standing
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode            <= scp_pkg::SCP_ALL_INPUT;
      cmp_three_owned <= 1'b0;
      cmp_four_owned  <= 1'b0;
    end else if (mode_load) begin
      unique case (mode_value)
        2'h0: begin
          mode            <= scp_pkg::SCP_ALL_INPUT;
          cmp_three_owned <= 1'b0;
          cmp_four_owned  <= 1'b0;
        end
        2'h1: begin
          mode            <= scp_pkg::SCP_EVENT_OUT;
          cmp_three_owned <= 1'b0;
          cmp_four_owned  <= 1'b0;
        end
        2'h2: begin
          if (cmp_ok) begin
            mode            <= scp_pkg::SCP_CMP_OUT;
            cmp_three_owned <= accept_three;
            cmp_four_owned  <= accept_four;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // refusal flag, one-cycle pulse
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_refused <= 1'b0;
    end else begin
      mode_refused <= mode_load && ((mode_value == 2'h2 && !cmp_ok)
                      || mode_value == 2'h3);
    end
  end

  // output data: address on entry, then matched memory data per nibble
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_data <= scp_pkg::NONE_OUT;
    end else if (mode_load && mode_value == 2'h2 && cmp_ok) begin
      out_data[scp_pkg::HI_LSB +: scp_pkg::GRP_W] <= cmp_three_addr[3:0];
      out_data[scp_pkg::LO_LSB +: scp_pkg::GRP_W] <= cmp_four_addr[3:0];
    end else begin
      if (cmp_three_owned && cmp_three_hit) begin
        out_data[scp_pkg::HI_LSB +: scp_pkg::GRP_W] <= mem_data[3:0];
      end
      if (cmp_four_owned && cmp_four_hit) begin
        out_data[scp_pkg::LO_LSB +: scp_pkg::GRP_W] <= mem_data[3:0];
      end
    end
  end

  // event pin held low one cycle per fire, only while in event mode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_hold <= 1'b0;
    end else begin
      event_hold <= event_fire && mode == scp_pkg::SCP_EVENT_OUT;
    end
  end

  // pin enables and input masking by mode
  always_comb begin
    in_mask   = ~scp_pkg::NONE_OUT;
    probe_oe  = scp_pkg::NONE_OUT;
    probe_out = scp_pkg::NONE_OUT;
    unique case (mode)
      scp_pkg::SCP_ALL_INPUT: begin
        probe_oe = scp_pkg::NONE_OUT;
      end
      scp_pkg::SCP_EVENT_OUT: begin
        // open collector: enable only while pulling low
        probe_oe[scp_pkg::EVT_BIT] = event_hold;
        in_mask[scp_pkg::EVT_BIT]  = 1'b0;
      end
      scp_pkg::SCP_CMP_OUT: begin
        probe_oe[scp_pkg::HI_LSB +: scp_pkg::GRP_W] = {scp_pkg::GRP_W{cmp_three_owned}};
        probe_oe[scp_pkg::LO_LSB +: scp_pkg::GRP_W] = {scp_pkg::GRP_W{cmp_four_owned}};
        probe_out = out_data;
        in_mask   = ~probe_oe;
      end
      default: begin
      end
    endcase
  end

  // input levels to trace and event conditions, registered
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trace_data <= scp_pkg::NONE_OUT;
      event_term <= scp_pkg::NONE_OUT;
    end else begin
      trace_data <= probe_in & in_mask;
      event_term <= probe_in & in_mask;
    end
  end

  assign mode_readback = mode;
  assign event_out     = event_hold;

  scp_pass_counter u_pass (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .pass_load  (pass_load),
    .pass_value (pass_value),
    .detect     (event_detect),
    .pass_count (pass_count),
    .event_fire (event_fire)
  );

  // input mode held over two edges, so the trace has seen unmasked pins
  sequence s_all_input_held;
    mode == scp_pkg::SCP_ALL_INPUT ##1 mode == scp_pkg::SCP_ALL_INPUT;
  endsequence

  // a fire in event mode with no mode change under way
  sequence s_fire_in_event_mode;
    event_fire && mode == scp_pkg::SCP_EVENT_OUT && !mode_load;
  endsequence

  AST_ALL_INPUT_NO_DRIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode == scp_pkg::SCP_ALL_INPUT |-> probe_oe == scp_pkg::NONE_OUT)
    else $error("pin driven in all-input mode");
  AST_EVENT_BIT_ONLY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode == scp_pkg::SCP_EVENT_OUT |-> probe_oe[7:1] == 7'h00)
    else $error("upper pin driven in event mode");
  AST_OPEN_COLLECTOR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    probe_oe[scp_pkg::EVT_BIT] && mode == scp_pkg::SCP_EVENT_OUT
      |-> !probe_out[scp_pkg::EVT_BIT])
    else $error("event pin driven high");
  AST_EVENT_PULL_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_fire_in_event_mode |=> probe_oe[scp_pkg::EVT_BIT] && !probe_out[scp_pkg::EVT_BIT])
    else $error("fire did not pull the event pin low");
  AST_GROUP_MAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode == scp_pkg::SCP_CMP_OUT |-> probe_oe == {{4{cmp_three_owned}}, {4{cmp_four_owned}}})
    else $error("group enables do not follow comparators");
  AST_REFUSE_BUSY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_load && mode_value == 2'h2 && sel_cmp_four && cmp_four_busy
      |=> mode_refused && !$changed(mode))
    else $error("busy comparator taken for probe output");
  AST_ENTRY_ADDR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_load && mode_value == 2'h2 && cmp_ok
      |=> out_data[3:0] == $past(cmp_four_addr[3:0]))
    else $error("entry value not the programmed address");
  AST_TRACE_INPUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_all_input_held |-> trace_data == $past(probe_in))
    else $error("trace does not follow inputs");
endmodule

// [dv/scp_board.sv]
// target board model seen through the probe clip
module scp_board (
  input  wire logic [7:0] probe_out,
  input  wire logic [7:0] probe_oe,
  input  wire logic [7:0] board_val,
  input  wire logic [7:0] board_drv,
  output logic      [7:0] probe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // clip drive wins; a free pin shows the pull-up on bit 0, else the inverted board value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (probe_oe[i]) begin
        probe_in[i] = probe_out[i];
      end else if (board_drv[i]) begin
        probe_in[i] = board_val[i];
      end else begin
        probe_in[i] = (i == 0) ? 1'b1 : ~board_val[i];
      end
    end
  end
endmodule

// [dv/tb.sv]
// self-checking bench for the sense clip mode and pass count block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       reset_n, mode_load, sel_cmp_three, sel_cmp_four, cmp_three_busy;
  logic       cmp_four_busy, cmp_three_hit, cmp_four_hit, event_detect, pass_load;
  logic       cmp_three_owned, cmp_four_owned, mode_refused, event_out;
  logic [1:0] mode_value, mode_readback;
  logic [7:0] cmp_three_addr, cmp_four_addr, mem_data, pass_value, probe_in, probe_out;
  logic [7:0] probe_oe, trace_data, event_term, pass_count, board_val, board_drv;
  int         failures = 0;
  int         checked = 0;
  int         cycles = 0;

  scp_sense_clip dut (.sys_clk, .reset_n, .mode_load, .mode_value, .sel_cmp_three,
    .sel_cmp_four, .cmp_three_busy, .cmp_four_busy, .cmp_three_addr, .cmp_four_addr,
    .cmp_three_hit, .cmp_four_hit, .mem_data, .event_detect, .pass_load, .pass_value,
    .probe_in, .probe_out, .probe_oe, .trace_data, .event_term, .mode_readback,
    .cmp_three_owned, .cmp_four_owned, .mode_refused, .pass_count, .event_out);
  scp_board board (.probe_out, .probe_oe, .board_val, .board_drv, .probe_in);

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one-cycle load pulses, launched and dropped on falling edges;
  // a quiet edge first, so back-to-back calls never redrive in one step
  task automatic set_mode(input logic [1:0] v);
    tick(1);
    mode_value = v;
    mode_load = 1'b1;
    tick(1);
    mode_load = 1'b0;
  endtask

  task automatic set_pass(input logic [7:0] v);
    tick(1);
    pass_value = v;
    pass_load = 1'b1;
    tick(1);
    pass_load = 1'b0;
  endtask

  task automatic detects(input int n);
    event_detect = 1'b1;
    tick(n);
    event_detect = 1'b0;
  endtask

  // the pulse lands two edges after the last detect; four cycles is ample
  task automatic fire_check(input logic exp);
    logic fired = 1'b0;
    repeat (4) begin
      if (event_out === 1'b1) begin
        fired = 1'b1;
        chk({6'h00, probe_oe[0], probe_in[0]}, 8'h02);
      end
      tick(1);
    end
    chk({7'h00, fired}, {7'h00, exp});
  endtask

  task automatic t_input();
    board_drv = 8'hff;
    board_val = 8'ha5;
    set_mode(2'h0);
    tick(2);
    chk(probe_oe, 8'h00);
    chk(trace_data, 8'ha5);
    chk(event_term, 8'ha5);
  endtask

  task automatic t_event();
    board_drv = 8'hfe;
    board_val = 8'h3c;
    set_mode(2'h1);
    chk({6'h00, mode_readback}, 8'h01);
    tick(2);
    chk(probe_oe, 8'h00);
    chk(trace_data, 8'h3c);
    set_pass(8'h03);
    set_pass(8'h00);
    chk(pass_count, 8'h03);
    detects(2);
    fire_check(1'b0);
    detects(1);
    fire_check(1'b1);
    detects(2);
    fire_check(1'b0);
    detects(1);
    fire_check(1'b1);
    set_pass(8'hff);
    chk(pass_count, 8'hff);
  endtask

  task automatic t_cmp();
    cmp_three_addr = 8'h3c;
    cmp_four_addr = 8'hc5;
    sel_cmp_three = 1'b1;
    sel_cmp_four = 1'b1;
    set_mode(2'h2);
    chk(probe_oe, 8'hff);
    chk(probe_out, 8'hc5);
    chk({6'h00, cmp_three_owned, cmp_four_owned}, 8'h03);
    mem_data = 8'h79;
    cmp_three_hit = 1'b1;
    tick(1);
    cmp_three_hit = 1'b0;
    mem_data = 8'h8e;
    cmp_four_hit = 1'b1;
    tick(1);
    cmp_four_hit = 1'b0;
    tick(1);
    chk(probe_out, 8'h9e);
    sel_cmp_three = 1'b0;
    set_mode(2'h2);
    chk(probe_oe, 8'h0f);
    chk(probe_out & 8'h0f, 8'h05);
    tick(1);
    chk(trace_data, 8'h30);
  endtask

  // refused requests leave the mode where it was
  task automatic t_refuse();
    set_mode(2'h0);
    cmp_four_busy = 1'b1;
    set_mode(2'h2);
    chk({5'h00, mode_refused, mode_readback}, 8'h04);
    cmp_four_busy = 1'b0;
    sel_cmp_four = 1'b0;
    set_mode(2'h2);
    chk({5'h00, mode_refused, mode_readback}, 8'h04);
    set_mode(2'h3);
    chk({5'h00, mode_refused, mode_readback}, 8'h04);
    tick(1);
    chk({5'h00, mode_refused, mode_readback}, 8'h00);
  endtask

  // reset in mid-run brings back input mode and a pass count of one
  task automatic t_reset();
    set_pass(8'h07);
    set_mode(2'h1);
    reset_n = 1'b0;
    tick(2);
    chk({6'h00, mode_readback}, 8'h00);
    chk(pass_count, 8'h01);
    reset_n = 1'b1;
    tick(2);
    chk(probe_oe, 8'h00);
    chk(pass_count, 8'h01);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard, well above the fewer than a hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    {reset_n, mode_load, mode_value, sel_cmp_three, sel_cmp_four, cmp_three_busy} = '0;
    {cmp_four_busy, cmp_three_hit, cmp_four_hit, event_detect, pass_load} = '0;
    {cmp_three_addr, cmp_four_addr, mem_data, pass_value, board_val, board_drv} = '0;
    tick(20);
    reset_n = 1'b1;
    tick(1);
    chk(pass_count, 8'h01);
    chk(probe_oe, 8'h00);
    t_input();
    t_event();
    t_cmp();
    t_refuse();
    t_reset();
    end_sim();
  end
endmodule
